// ---- include/fbs_params.svh ----
// Purpose: Constants of the flow-through burst SRAM port.
// Assumes: Included by its bare name.
// Notes: Definitions only.
`ifndef FBS_PARAMS_SVH
`define FBS_PARAMS_SVH

`define FBS_ADDR_W 18
`define FBS_HIGH_W 16
`define FBS_BURST_W 2
`define FBS_DATA_W 32
`define FBS_LANE_W 8
`define FBS_LANES 4
`define FBS_BEAT_FIRST 2'h0
`define FBS_BEAT_STEP 2'h1
`define FBS_DQ_RESET 32'h0000_0000
`define FBS_STRAP_RESET 1'h1

`endif

// ---- include/fbs_pkg.sv ----
// Purpose: Types shared by the burst SRAM port.
// Assumes: Compiled before the design file.
// Notes: One-hot access state codes.
`default_nettype none
package fbs_pkg;
   // Access carried by the current cycle
   typedef enum logic [2:0] {
      FBS_DESEL = 3'h1,
      FBS_READ = 3'h2,
      FBS_WRITE = 3'h4
   } fbs_access_t;

   // Burst order strap meaning
   typedef enum logic {
      FBS_LINEAR = 1'h0,
      FBS_INTERLEAVED = 1'h1
   } fbs_order_t;
endpackage
`default_nettype wire

// ---- rtl/fbs_sram_port.sv ----
// Purpose: Flow-through burst SRAM port, 256K words, with its storage.
// Assumes: Controller runs on clock_i; output enable pin is asynchronous.
// Notes: Read data is loaded at the capture edge, giving flow-through timing.
//        The reset port clears control state and the read data register; storage powers up unknown.
//        The drive enable mixes the asynchronous enable pin after its flop.
// Behaviour
// (R01) Register all synchronous inputs on rising edge
// (R02) Registered address picks one of 256K words
// (R03) Low two address bits load burst counter
// (R04) Active-low byte writes qualify with write strobe
// (R05) Write strobe sampled only while qualify low
// (R06) Controller drives strobe low to write
// (R07) Advance high steps burst counter, no load
// (R08) Advance low loads address and controls
// (R09) Controller loads fresh address after deselect
// (R10) Edges ignored while clock qualify high
// (R11) Select only first low, second high, third low
// (R12) Output enable low allows read drive
// (R13) Output enable high tristates pins immediately
// (R14) No drive on write, post-deselect, deselected
// (R15) Qualify high holds all state, no deselect
// (R16) Strap low linear, high interleaved burst
// (R17) Counter alone changes low bits, wraps four
`timescale 1ns/1ns
`default_nettype none
`include "fbs_params.svh"

module fbs_sram_port #(
   parameter int ADDR_W = `FBS_ADDR_W,
   parameter int HIGH_W = `FBS_HIGH_W,
   parameter int DATA_W = `FBS_DATA_W,
   parameter int LANES = `FBS_LANES
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // Address, upper bits and burst start bits
   input wire logic [HIGH_W-1:0] addr_high_i,
   input wire logic burst_addr_low_bit0_i,
   input wire logic burst_addr_low_bit1_i,
   // Synchronous controls
   input wire logic [LANES-1:0] byte_lane_write_n_i,
   input wire logic write_strobe_n_i,
   input wire logic advance_or_load_i,
   input wire logic clock_qualify_n_i,
   input wire logic chip_select_first_n_i,
   input wire logic chip_select_second_i,
   input wire logic chip_select_third_n_i,
   // Asynchronous output enable and burst order strap
   input wire logic output_enable_n_i,
   input wire fbs_pkg::fbs_order_t burst_order_i,
   // Data pins as three signals
   input wire logic [DATA_W-1:0] dq_i,
   output logic [DATA_W-1:0] dq_o,
   output logic dq_oe_o
);
   import fbs_pkg::*;

   // Word count follows the address width
   localparam int WORDS = 1 << ADDR_W;
   localparam int LANE_W = `FBS_LANE_W;

   // Storage
   logic [DATA_W-1:0] mem [WORDS];

   // Captured access state
   fbs_access_t access;
   logic [HIGH_W-1:0] addr_high;
   logic [`FBS_BURST_W-1:0] burst_start;
   logic [`FBS_BURST_W-1:0] beat;
   logic wr_pend;
   logic [ADDR_W-1:0] wr_addr;
   logic [LANES-1:0] wr_lane_n;
   logic read_drive;
   logic order_s1;
   logic order_s2;

   // Next values
   fbs_access_t next_access;
   logic [HIGH_W-1:0] next_addr_high;
   logic [`FBS_BURST_W-1:0] next_start;
   logic [`FBS_BURST_W-1:0] next_beat;
   logic [ADDR_W-1:0] next_addr;
   logic [DATA_W-1:0] next_read;

   // Decode helpers
   logic selected;
   logic load;
   logic linear;

   // Low address of a beat; both orders wrap within four words
   function automatic logic [`FBS_BURST_W-1:0] burst_low(
      input logic [`FBS_BURST_W-1:0] start,
      input logic [`FBS_BURST_W-1:0] step,
      input logic lin
   );
      // Linear steps by addition, interleaved by exclusive or
      burst_low = lin ? start + step : start ^ step; // R16 R17
   endfunction

   // Replace enabled byte lanes of a word
   function automatic logic [DATA_W-1:0] lane_merge(
      input logic [DATA_W-1:0] old_word,
      input logic [DATA_W-1:0] new_word,
      input logic [LANES-1:0] lane_n
   );
      logic [DATA_W-1:0] word;
      // Lanes left high keep the stored byte
      word = old_word;
      for (int i = 0; i < LANES; i++) begin
         if (!lane_n[i]) begin
            word[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W]; // R04
         end
      end
      lane_merge = word;
   endfunction

   // Strap is static but arrives from a pin: two flops first
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         order_s1 <= `FBS_STRAP_RESET;
         order_s2 <= `FBS_STRAP_RESET;
      end else begin
         order_s1 <= burst_order_i;
         order_s2 <= order_s1;
      end
   end

   // Strap changes take effect two edges later
   assign linear = (order_s2 == FBS_LINEAR); // R16

   // Decode of the sampled pins for the coming cycle
   always_comb begin
      selected = !chip_select_first_n_i && chip_select_second_i && !chip_select_third_n_i; // R11
      load = !advance_or_load_i; // R08
      // Load edge: selects and strobe pick the kind of access
      if (load) begin
         if (!selected) begin
            next_access = FBS_DESEL; // R11
         end else if (!write_strobe_n_i) begin
            next_access = FBS_WRITE; // R06
         end else begin
            next_access = FBS_READ; // R06
         end
         next_addr_high = addr_high_i; // R02 R08
         next_start = {burst_addr_low_bit1_i, burst_addr_low_bit0_i}; // R03
         // A new access always starts at beat zero
         next_beat = `FBS_BEAT_FIRST;
      end else begin
         // Advance keeps the access kind, even a deselect
         next_access = access; // R07 R09
         next_addr_high = addr_high; // R17
         next_start = burst_start;
         next_beat = beat + `FBS_BEAT_STEP; // R07 R17
      end
      // Upper bits from the capture, low bits from the counter
      next_addr = {next_addr_high, burst_low(next_start, next_beat, linear)};
      // Bypass a write landing this edge on the word being read
      if (wr_pend && wr_addr == next_addr) begin
         next_read = lane_merge(mem[next_addr], dq_i, wr_lane_n);
      end else begin
         next_read = mem[next_addr];
      end
   end

   // Access state; qualify high stretches the cycle
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         access <= FBS_DESEL;
         addr_high <= '0;
         burst_start <= `FBS_BEAT_FIRST;
         beat <= `FBS_BEAT_FIRST;
      end else if (!clock_qualify_n_i) begin // R10 R15
         access <= next_access; // R01
         addr_high <= next_addr_high; // R01
         burst_start <= next_start; // R01 R03
         // Counter wraps by its own width, after four beats
         beat <= next_beat;
      end
   end

   // Write address phase; data follows one qualified edge later
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wr_pend <= 1'h0;
         wr_addr <= '0;
         wr_lane_n <= '1;
      end else if (!clock_qualify_n_i) begin // R05 R10
         wr_pend <= (next_access == FBS_WRITE); // R05
         wr_addr <= next_addr;
         // Lanes follow every qualified edge; unused on reads
         wr_lane_n <= byte_lane_write_n_i; // R01 R04
      end
   end

   // Write data phase into storage; no reset on the array
   always_ff @(posedge clock_i) begin
      // A held edge also stretches the data phase
      if (!clock_qualify_n_i && wr_pend) begin // R10
         mem[wr_addr] <= lane_merge(mem[wr_addr], dq_i, wr_lane_n); // R04
      end
   end

   // Read data and synchronous drive permission
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dq_o <= `FBS_DQ_RESET;
         read_drive <= 1'h0;
      end else if (!clock_qualify_n_i) begin // R15
         // Data loads even when not driven; only the enable hides it
         dq_o <= next_read; // R02
         // No drive for writes, while deselected or just after
         read_drive <= (next_access == FBS_READ) && (access != FBS_DESEL); // R14
      end
   end

   // Enable pin acts without a clock, so it gates the flop here
   // Trade-off: not a pure flop output, as the pin must act at once
   assign dq_oe_o = read_drive && !output_enable_n_i; // R12 R13

endmodule // fbs_sram_port
`default_nettype wire

// ---- sim/fbs_sram_port_asserts.sv ----
// Purpose: Port checks for the burst SRAM port.
// Assumes: Bound into fbs_sram_port.
// Notes: Word values are judged by the bench.
`timescale 1ns/1ns
`default_nettype none
module fbs_sram_port_asserts #(parameter int DATA_W = 32) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // Controls
   input wire logic advance_or_load_i,
   input wire logic write_strobe_n_i,
   input wire logic clock_qualify_n_i,
   input wire logic chip_select_first_n_i,
   input wire logic chip_select_second_i,
   input wire logic chip_select_third_n_i,
   input wire logic output_enable_n_i,
   // Outputs
   input wire logic [DATA_W-1:0] dq_o,
   input wire logic dq_oe_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   // Edge shapes; advance ignores selects, so only loads can deselect
   logic ld, sel, rd, off, adv;
   assign ld = !clock_qualify_n_i && !advance_or_load_i;
   assign sel = !chip_select_first_n_i && chip_select_second_i && !chip_select_third_n_i;
   assign rd = ld && sel && write_strobe_n_i;
   assign off = ld && !sel;
   assign adv = !clock_qualify_n_i && advance_or_load_i;
   a_oe_pin_off: assert property (output_enable_n_i |-> !dq_oe_o) else $error("drive, oe high");
   a_hold_data: assert property (clock_qualify_n_i |=> $stable(dq_o)) else $error("data moved");
   a_hold_drive: assert property (clock_qualify_n_i ##1 $stable(output_enable_n_i) |-> $stable(dq_oe_o))
      else $error("drive moved");
   a_write_quiet: assert property ((ld && sel && !write_strobe_n_i) |=> !dq_oe_o) else $error("drive, write");
   a_desel_quiet: assert property (off |=> !dq_oe_o) else $error("drive, desel");
   a_adv_desel: assert property (off ##1 adv |=> !dq_oe_o) else $error("drive, adv");
   a_emerge_quiet: assert property (off ##1 adv ##1 rd |=> !dq_oe_o) else $error("drive, emerge");
   a_read_drive: assert property (rd ##1 (rd && !output_enable_n_i) |=> (dq_oe_o || output_enable_n_i))
      else $error("no drive");
   // Main scenarios seen
   cover property (off ##1 adv ##1 rd);
   cover property (rd ##1 clock_qualify_n_i);
   cover property ((ld && sel && !write_strobe_n_i) ##1 rd);
endmodule // fbs_sram_port_asserts
bind fbs_sram_port fbs_sram_port_asserts #(.DATA_W(DATA_W)) fbs_sram_port_asserts_inst (.*);
`default_nettype wire

// ---- sim/fbs_host_model.sv ----
// Purpose: Host controller model for the burst SRAM port.
// Assumes: Drives one ns after each rising edge.
// Notes: Released data lines carry the inverse value.
`timescale 1ns/1ns
`default_nettype none
module fbs_host_model (
   // Clock
   input wire logic clock_i,
   // Bus towards the port
   output logic [17:0] addr_o,
   output logic [3:0] lanes_n_o,
   output logic [2:0] cs_o,
   output logic we_n_o,
   output logic adv_o,
   output logic cq_n_o,
   output logic [31:0] wdata_o
);
   logic pend = 1'b0;
   logic [31:0] wd = 32'h0;
   // Deselected at time zero
   initial begin
      {addr_o, lanes_n_o, cs_o, we_n_o, adv_o, cq_n_o, wdata_o} = '0;
   end
   // One cycle; write data waits for the next qualified edge
   task automatic cyc(input logic q, a, w, input logic [2:0] c, input logic [17:0] ad,
      input logic [3:0] l, input logic [31:0] d);
      @(posedge clock_i);
      #1;
      wdata_o = pend ? wd : ~wdata_o;
      pend = q ? pend : (!a && !w && c == 3'h2);
      wd = q ? wd : d;
      {cq_n_o, adv_o, we_n_o, cs_o, addr_o, lanes_n_o} = {q, a, w, c, ad, l};
   endtask
endmodule // fbs_host_model
`default_nettype wire

// ---- sim/fbs_sram_port_tb_top.sv ----
// Purpose: Self-checking bench for the burst SRAM port.
// Assumes: Host model drives the bus; bench drives strap and enable.
// Notes: A check judges the access loaded one call earlier.
`timescale 1ns/1ns
`default_nettype none
module fbs_sram_port_tb_top;
   import fbs_pkg::*;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic output_enable_n_i = 1'b0;
   fbs_order_t burst_order_i = FBS_LINEAR;
   wire [15:0] addr_high_i;
   wire burst_addr_low_bit0_i, burst_addr_low_bit1_i, write_strobe_n_i, advance_or_load_i, clock_qualify_n_i;
   wire chip_select_first_n_i, chip_select_second_i, chip_select_third_n_i;
   wire [3:0] byte_lane_write_n_i;
   wire [31:0] dq_i;
   logic [31:0] dq_o;
   logic dq_oe_o;
   int error_cnt = 0;
   int checks = 0;
   fbs_sram_port fbs_sram_port_inst (.*);
   fbs_host_model fbs_host_model_inst (.clock_i(clock_i),
      .addr_o({addr_high_i, burst_addr_low_bit1_i, burst_addr_low_bit0_i}), .lanes_n_o(byte_lane_write_n_i),
      .cs_o({chip_select_first_n_i, chip_select_second_i, chip_select_third_n_i}), .we_n_o(write_strobe_n_i),
      .adv_o(advance_or_load_i), .cq_n_o(clock_qualify_n_i), .wdata_o(dq_i));
   // 10 MHz clock
   initial begin
      forever #50 clock_i = ~clock_i;
   end
   task automatic chk(input logic [31:0] got, exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ck_oe(input logic e);
      chk({31'h0, dq_oe_o}, {31'h0, e});
   endtask
   task automatic wr(input logic [17:0] a, input logic [3:0] l, input logic [31:0] d);
      fbs_host_model_inst.cyc(0, 0, 0, 3'h2, a, l, d);
   endtask
   task automatic rd(input logic [17:0] a);
      fbs_host_model_inst.cyc(0, 0, 1, 3'h2, a, 4'hf, 32'h0);
   endtask
   // Advance, or a held edge when q is high
   task automatic adv(input logic q);
      fbs_host_model_inst.cyc(q, 1, 1, 3'h2, 18'h0, 4'hf, 32'h0);
   endtask
   // Lane merge, then a read of the word at the very next edge
   task automatic t_merge();
      wr(18'h12341, 4'h0, 32'ha5a5_0f0f);
      wr(18'h12341, 4'he, 32'h0000_0033);
      ck_oe(0);
      rd(18'h12341);
      rd(18'h12341);
      chk(dq_o, 32'ha5a5_0f33);
      ck_oe(1);
      // Held write load must leave storage and drive alone
      fbs_host_model_inst.cyc(1, 0, 0, 3'h2, 18'h12341, 4'h0, 32'h0);
      rd(18'h12341);
      ck_oe(1);
      rd(18'h12341);
      chk(dq_o, 32'ha5a5_0f33);
   endtask
   // Both orders from start address one, with one held edge mid-burst
   task automatic t_burst();
      logic [1:0] lo;
      for (int i = 0; i < 4; i++) wr({16'h00a5, 2'(i)}, 4'h0, 32'hb0 + i);
      for (int o = 0; o < 2; o++) begin
         burst_order_i = fbs_order_t'(o);
         rd({16'h00a5, 2'h1});
         rd({16'h00a5, 2'h1});
         for (int k = 0; k < 4; k++) begin
            if (k == 2) adv(1);
            adv(0);
            lo = (o == 0) ? 2'(1 + k) : 2'(1 ^ k);
            chk(dq_o, 32'hb0 | 32'(lo));
         end
      end
   endtask
   // Each select pin wrong on its own, an advance, then re-entry reads
   task automatic t_desel();
      logic [2:0] pat [3] = '{3'h6, 3'h0, 3'h3};
      foreach (pat[i]) begin
         fbs_host_model_inst.cyc(0, 0, 1, pat[i], 18'h12341, 4'hf, 32'h0);
         adv(0);
         ck_oe(0);
         rd(18'h12341);
         ck_oe(0);
         rd(18'h12341);
         ck_oe(0);
         rd(18'h12341);
         ck_oe(1);
         chk(dq_o, 32'ha5a5_0f33);
         output_enable_n_i = 1'b1;
         #1;
         ck_oe(0);
         output_enable_n_i = 1'b0;
      end
   endtask
   task automatic results();
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Reset for 10 cycles, then the scenarios
   initial begin
      repeat (10) @(posedge clock_i);
      #1;
      sys_rst_i = 1'b0;
      t_merge();
      t_burst();
      t_desel();
      results();
   end
   // Hang guard, far beyond the few dozen cycles used
   initial begin
      #200000;
      error_cnt++;
      results();
   end
endmodule // fbs_sram_port_tb_top
`default_nettype wire
